// [core/fwp_dev.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fwp_map.svh"
module fwp_dev
    import fwp_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h5A,  // arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] CAP_CODE = 8'h17   // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    fwp_if.dev link,
    input wire logic auto_inc_set,
    output logic [7:0] status_ff,
    output logic [7:0] status1_ff,
    output logic sr_armed_ff
);
    logic [3:0] pin_in;
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] stab_ff;
    logic [3:0] prev_ff;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic mosi_s;
    logic wp_low;
    fwp_dev_st_t st_ff;
    logic [7:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] opcode_ff;
    logic [7:0] data0_ff;
    logic [7:0] data1_ff;
    logic addr_lsb_ff;
    logic miso_ff;
    logic miso_oe_ff;
    logic is_legacy;
    logic out_phase;
    logic [7:0] id_byte;
    logic done;
    logic sr_len_ok;
    logic sr_allowed;
    logic sr_locked;
    localparam logic [3:0] PIN_RST = `FWP_PIN_RESET;

    assign pin_in = {link.wp_n, link.mosi, link.sck, link.cs_n};

    // three-stage sync; level accepted once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_ff <= `FWP_PIN_RESET;
            s2_ff <= `FWP_PIN_RESET;
            s3_ff <= `FWP_PIN_RESET;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_stab
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                stab_ff[i] <= PIN_RST[i];
                prev_ff[i] <= PIN_RST[i];
            end else begin
                if (s2_ff[i] == s3_ff[i]) begin
                    stab_ff[i] <= s3_ff[i];
                end
                prev_ff[i] <= stab_ff[i];
            end
        end
    end

    // edge events of the sampled link
    assign cs_rise = stab_ff[0] & ~prev_ff[0];
    assign cs_fall = ~stab_ff[0] & prev_ff[0];
    assign sck_rise = stab_ff[1] & ~prev_ff[1] & ~stab_ff[0];
    assign sck_fall = ~stab_ff[1] & prev_ff[1] & ~stab_ff[0];
    assign mosi_s = stab_ff[2];
    assign wp_low = ~stab_ff[3];

    // frame tracking: chip-enable high always returns to deselect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= DS_DESELECT;
        end else if (stab_ff[0]) begin
            st_ff <= DS_DESELECT;
        end else if (cs_fall) begin
            st_ff <= DS_OPCODE;
        end else if (sck_rise && st_ff == DS_OPCODE && cnt_ff == `FWP_LEN_OPCODE - 8'h01) begin
            st_ff <= DS_BODY;
        end
    end

    // input shifter, msb first on rising sck
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            shift_ff <= 8'h00;
            opcode_ff <= 8'h00;
            data0_ff <= 8'h00;
            data1_ff <= 8'h00;
            addr_lsb_ff <= 1'b0;
        end else if (cs_fall) begin
            cnt_ff <= 8'h00;
        end else if (sck_rise) begin
            cnt_ff <= cnt_ff + 8'h01; // wraps; legacy output uses bit 3 for parity but also needs the count at or above 0x20
            shift_ff <= {shift_ff[6:0], mosi_s};
            if (cnt_ff == `FWP_LEN_OPCODE - 8'h01) begin
                opcode_ff <= {shift_ff[6:0], mosi_s};
            end
            if (cnt_ff == `FWP_LEN_SR_BYTE - 8'h01) begin
                data0_ff <= {shift_ff[6:0], mosi_s};
            end
            if (cnt_ff == `FWP_LEN_SR_WORD - 8'h01) begin
                data1_ff <= {shift_ff[6:0], mosi_s};
            end
            if (cnt_ff == `FWP_LEN_ADDR_END) begin
                addr_lsb_ff <= mosi_s;
            end
        end
    end

    // command decode evaluated at the frame end
    assign done = cs_rise && st_ff == DS_BODY;
    assign sr_len_ok = cnt_ff == `FWP_LEN_SR_BYTE || cnt_ff == `FWP_LEN_SR_WORD;
    assign sr_allowed = status_ff[`FWP_SR_LATCH] | sr_armed_ff;
    assign sr_locked = wp_low & status_ff[`FWP_SR_LOCK];

    // arm lasts exactly one following command
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sr_armed_ff <= 1'b0;
        end else if (done) begin
            sr_armed_ff <= opcode_ff == `FWP_OP_SR_ARM && cnt_ff == `FWP_LEN_OPCODE;
        end
    end

    // status registers; auto-increment set from programming logic wins over a clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_ff <= `FWP_SR_RESET;
            status1_ff <= `FWP_SR1_RESET;
        end else begin
            if (done && cnt_ff == `FWP_LEN_OPCODE) begin
                case (opcode_ff)
                    `FWP_OP_LATCH_SET: status_ff[`FWP_SR_LATCH] <= 1'b1;
                    `FWP_OP_LATCH_CLR: begin
                        // only the latch and auto-increment bits drop; an internal program runs on
                        status_ff[`FWP_SR_LATCH] <= 1'b0;
                        status_ff[`FWP_SR_AUTO_INC] <= 1'b0;
                    end
                    default: ;
                endcase
            end
            if (done && opcode_ff == `FWP_OP_SR_WRITE && sr_len_ok && sr_allowed) begin
                status_ff[`FWP_SR_LATCH] <= 1'b0;
                if (!sr_locked) begin
                    // one write may lock and change protection together
                    status_ff[`FWP_SR_BP_HI:`FWP_SR_BP_LO] <=
                        data0_ff[`FWP_SR_BP_HI:`FWP_SR_BP_LO];
                    status_ff[`FWP_SR_LOCK] <= wp_low ?
                        (status_ff[`FWP_SR_LOCK] | data0_ff[`FWP_SR_LOCK]) :
                        data0_ff[`FWP_SR_LOCK];
                    if (cnt_ff == `FWP_LEN_SR_WORD) begin
                        status1_ff <= (status1_ff & ~`FWP_SR1_WMASK) |
                            (data1_ff & `FWP_SR1_WMASK);
                    end
                end
            end
            if (auto_inc_set) begin
                status_ff[`FWP_SR_AUTO_INC] <= 1'b1;
            end
        end
    end

    // identification byte for the current output slot
    assign is_legacy = opcode_ff == `FWP_OP_LEGACY_ID_A || opcode_ff == `FWP_OP_LEGACY_ID_B;
    always_comb begin
        id_byte = 8'h00;
        out_phase = 1'b0;
        if (opcode_ff == `FWP_OP_JEDEC_ID) begin
            out_phase = 1'b1;
            case (cnt_ff[7:3])
                5'h01: id_byte = MFR_CODE;
                5'h02: id_byte = TYPE_CODE;
                5'h03: id_byte = CAP_CODE;
                default: id_byte = 8'h00;
            endcase
        end else if (is_legacy && cnt_ff >= `FWP_LEN_LEGACY_OUT) begin
            out_phase = 1'b1;
            id_byte = (cnt_ff[3] ^ addr_lsb_ff) ? CAP_CODE : MFR_CODE;
        end
    end

    // output shifts on falling sck, released as soon as chip enable rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            miso_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else if (stab_ff[0]) begin
            miso_oe_ff <= 1'b0;
        end else if (sck_fall && st_ff == DS_BODY && out_phase) begin
            miso_ff <= id_byte[~cnt_ff[2:0]];
            miso_oe_ff <= 1'b1;
        end
    end

    assign link.miso_o = miso_ff;
    assign link.miso_oe = miso_oe_ff;
endmodule
`default_nettype wire

// [inc/fwp_map.svh]
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH
// opcodes seen on the link
`define FWP_OP_LATCH_SET 8'h06
`define FWP_OP_LATCH_CLR 8'h04
`define FWP_OP_SR_ARM 8'h50
`define FWP_OP_SR_WRITE 8'h01
`define FWP_OP_JEDEC_ID 8'h9F
`define FWP_OP_LEGACY_ID_A 8'h90
`define FWP_OP_LEGACY_ID_B 8'hAB
// bit counts of complete command frames, plus the last address bit and the start of legacy output
`define FWP_LEN_OPCODE 8'h08
`define FWP_LEN_SR_BYTE 8'h10
`define FWP_LEN_SR_WORD 8'h18
`define FWP_LEN_ADDR_END 8'h1F
`define FWP_LEN_LEGACY_OUT 8'h20
// main status register fields
`define FWP_SR_LATCH 1
`define FWP_SR_BP_LO 2
`define FWP_SR_BP_HI 4
`define FWP_SR_AUTO_INC 6
`define FWP_SR_LOCK 7
`define FWP_SR_RESET 8'h00
// secondary status register: top and bottom protect are writable
`define FWP_SR1_WMASK 8'h18
`define FWP_SR1_RESET 8'h00
// synchroniser reset: {wp_n, mosi, sck, cs_n}
`define FWP_PIN_RESET 4'b1001
// host register byte offsets
`define FWP_REG_CTRL 4'h0
`define FWP_REG_TXD 4'h4
`define FWP_REG_RXD 4'h8
`define FWP_REG_STAT 4'hC
// host control field positions
`define FWP_CTRL_NB_LO 8
`define FWP_CTRL_NB_HI 13
`define FWP_CTRL_START 16
`define FWP_CTRL_WP 24
`define FWP_CTRL_RESET 32'h0100_0000
`define FWP_HALF_DEFAULT 8
`endif

// [inc/fwp_pkg.sv]
`default_nettype none
package fwp_pkg;
    typedef enum logic [1:0] {
        DS_DESELECT,
        DS_OPCODE,
        DS_BODY
    } fwp_dev_st_t;
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_LEAD,
        HS_XFER,
        HS_TRAIL,
        HS_GAP
    } fwp_host_st_t;
endpackage
`default_nettype wire

// [inc/fwp_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface fwp_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic wp_n;
    logic miso_o;
    logic miso_oe;
    wire logic miso;
    // released output reads as a pulled-up line
    assign miso = miso_oe ? miso_o : 1'b1;
    modport dev (input cs_n, input sck, input mosi, input wp_n, output miso_o, output miso_oe);
    modport host (output cs_n, output sck, output mosi, output wp_n, input miso);
endinterface
`default_nettype wire

// [core/fwp_host.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fwp_map.svh"
module fwp_host
    import fwp_pkg::*;
#(
    parameter int HALF = `FWP_HALF_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    fwp_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // shorter halves fail: the answer crosses both ends' synchronisers
    if (HALF < `FWP_HALF_DEFAULT || HALF > 255) begin : g_half_check
        $error("fwp_host: HALF out of range");
    end

    logic [3:0] aw_ff;
    logic [31:0] wd_ff;
    logic [3:0] ws_ff;
    logic [31:0] wmask;
    logic do_write;
    logic [31:0] ctrl_ff;
    logic [31:0] txd_ff;
    logic [31:0] rxd_ff;
    logic start;
    fwp_host_st_t st_ff;
    logic [7:0] div_ff;
    logic tick;
    logic [9:0] left_ff;
    logic [39:0] sh_ff;
    logic cs_n_ff;
    logic sck_ff;
    logic mosi_ff;
    logic m1_ff;
    logic m2_ff;
    logic m3_ff;
    logic miso_ff;

    // axi write: address and data taken in either order, answer after both
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            aw_ff <= 4'h0;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wd_ff <= s_axi_wdata;
                ws_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    assign s_axi_bresp = 2'b00;
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wmask = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};
    assign start = do_write && aw_ff[3:2] == `FWP_REG_CTRL >> 2 && ws_ff[2]
        && wd_ff[`FWP_CTRL_START] && st_ff == HS_IDLE;

    // software registers; start is a pulse, never stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff <= `FWP_CTRL_RESET;
            txd_ff <= 32'h0000_0000;
        end else if (do_write) begin
            case (aw_ff[3:2])
                `FWP_REG_CTRL >> 2: ctrl_ff <= ((ctrl_ff & ~wmask) | (wd_ff & wmask))
                    & ~(32'h0000_0001 << `FWP_CTRL_START);
                `FWP_REG_TXD >> 2: txd_ff <= (txd_ff & ~wmask) | (wd_ff & wmask);
                default: ;
            endcase
        end
    end

    // axi read, one word answered the cycle after the address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr[3:2])
                `FWP_REG_CTRL >> 2: s_axi_rdata <= ctrl_ff;
                `FWP_REG_TXD >> 2: s_axi_rdata <= txd_ff;
                `FWP_REG_RXD >> 2: s_axi_rdata <= rxd_ff;
                default: s_axi_rdata <= {31'h0000_0000, st_ff != HS_IDLE};
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    assign s_axi_rresp = 2'b00;

    // miso sampled through three flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            m1_ff <= 1'b1;
            m2_ff <= 1'b1;
            m3_ff <= 1'b1;
            miso_ff <= 1'b1;
        end else begin
            m1_ff <= link.miso;
            m2_ff <= m1_ff;
            m3_ff <= m2_ff;
            if (m2_ff == m3_ff) begin
                miso_ff <= m3_ff;
            end
        end
    end

    // half-period divider for sck
    always_ff @(posedge clk) begin
        if (!rst_n || st_ff == HS_IDLE || div_ff == 8'(HALF - 1)) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    assign tick = st_ff != HS_IDLE && div_ff == 8'(HALF - 1);

    // frame engine: mode 0, shift on fall, answer taken at end of high half
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= HS_IDLE;
            cs_n_ff <= 1'b1;
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
            left_ff <= 10'h000;
            sh_ff <= 40'h00_0000_0000;
            rxd_ff <= 32'h0000_0000;
        end else if (start) begin
            st_ff <= HS_LEAD;
            cs_n_ff <= 1'b0;
            mosi_ff <= wd_ff[7];
            sh_ff <= {wd_ff[6:0], txd_ff, 1'b0};
            left_ff <= 10'h008 + {1'b0, wd_ff[`FWP_CTRL_NB_HI:`FWP_CTRL_NB_LO], 3'h0};
        end else if (tick) begin
            case (st_ff)
                HS_LEAD: st_ff <= HS_XFER;
                HS_XFER: begin
                    sck_ff <= ~sck_ff;
                    if (sck_ff) begin
                        // synchronised answer lands after the rising edge,
                        // so the bit is taken just before the next shift
                        rxd_ff <= {rxd_ff[30:0], miso_ff};
                        left_ff <= left_ff - 10'h001;
                        mosi_ff <= sh_ff[39];
                        sh_ff <= {sh_ff[38:0], 1'b0};
                        if (left_ff == 10'h001) begin
                            st_ff <= HS_TRAIL;
                        end
                    end
                end
                HS_TRAIL: begin
                    cs_n_ff <= 1'b1;
                    st_ff <= HS_GAP;
                end
                HS_GAP: st_ff <= HS_IDLE;
                default: st_ff <= HS_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sck = sck_ff;
    assign link.mosi = mosi_ff;
    assign link.wp_n = ctrl_ff[`FWP_CTRL_WP];
endmodule
`default_nettype wire

// [tb/fwp_link_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module fwp_link_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic wp_n,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    // each serial clock half spans eight system clocks
    sequence s_high_half;
        sck [*8] ##1 !sck;
    endsequence
    sequence s_low_half;
        !sck [*8] ##1 (sck || cs_n);
    endsequence

    property p_idle_low;
        @(posedge clk) disable iff (!rst_n) cs_n |-> !sck;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("serial clock runs while deselected");

    property p_lead;
        @(posedge clk) disable iff (!rst_n) $fell(cs_n) |-> !sck [*8];
    endproperty
    a_lead: assert property (p_lead) else $error("serial clock rose too soon after select");

    property p_high_half;
        @(posedge clk) disable iff (!rst_n) $rose(sck) |-> s_high_half;
    endproperty
    a_high_half: assert property (p_high_half) else $error("serial clock high half wrong");

    property p_low_half;
        @(posedge clk) disable iff (!rst_n) $fell(sck) |-> s_low_half;
    endproperty
    a_low_half: assert property (p_low_half) else $error("low half or trail wrong");

    // data to the device may only move while the serial clock is low
    property p_mosi_hold;
        @(posedge clk) disable iff (!rst_n) sck |=> (!sck || $stable(mosi));
    endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("data in moved while clock high");

    property p_miso_shift;
        @(posedge clk) disable iff (!rst_n) (!cs_n && $changed(miso_o)) |-> !sck;
    endproperty
    a_miso_shift: assert property (p_miso_shift) else $error("data out moved while clock high");

    // synchroniser latency allows a few cycles before release
    property p_release;
        @(posedge clk) disable iff (!rst_n) cs_n [*8] |-> !miso_oe;
    endproperty
    a_release: assert property (p_release) else $error("data out still driven after deselect");

    property p_drive_sel;
        @(posedge clk) disable iff (!rst_n) $rose(miso_oe) |-> !cs_n;
    endproperty
    a_drive_sel: assert property (p_drive_sel) else $error("data out driven while deselected");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fwp_pkg::*;
    localparam logic [7:0] MFR = 8'h5A; // arbitrary value
    localparam logic [7:0] TYP = 8'h3C; // arbitrary value
    localparam logic [7:0] CAP = 8'h17; // arbitrary value
    localparam logic [7:0] OP_SET = 8'h06;
    localparam logic [7:0] OP_CLR = 8'h04;
    localparam logic [7:0] OP_ARM = 8'h50;
    localparam logic [7:0] OP_SRW = 8'h01;
    localparam logic [7:0] OP_JID = 8'h9F;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic auto_inc_set = 1'b0;
    logic wp_lvl = 1'b1;
    logic [7:0] status;
    logic [7:0] status1;
    logic armed;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    int fails = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    fwp_if link_if();
    fwp_dev #(.MFR_CODE(MFR), .TYPE_CODE(TYP), .CAP_CODE(CAP)) u_fwp_dev (.clk(clk),
        .rst_n(rst_n), .link(link_if), .auto_inc_set(auto_inc_set), .status_ff(status),
        .status1_ff(status1), .sr_armed_ff(armed));
    fwp_host #(.HALF(8)) u_fwp_host (.clk(clk), .rst_n(rst_n), .link(link_if),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    fwp_link_sva u_fwp_link_sva (.clk(clk), .rst_n(rst_n), .cs_n(link_if.cs_n),
        .sck(link_if.sck), .mosi(link_if.mosi), .wp_n(link_if.wp_n),
        .miso_o(link_if.miso_o), .miso_oe(link_if.miso_oe), .miso(link_if.miso));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // main status plus secondary status and arm flag in one look
    task automatic chk_sr(input logic [7:0] exp0, input logic [7:0] exp1, input logic arm);
        chk_word("status", {24'h0000_00, exp0}, {24'h0000_00, status});
        chk_word("status1", {24'h0000_00, exp1}, {24'h0000_00, status1});
        chk_word("armed", {31'h0000_0000, arm}, {31'h0000_0000, armed});
    endtask

    // write offers address and data together, holds each until taken
    // waits for the answer as long as it takes; only the watchdog ends a hang
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
    endtask

    // one framed command, then wait out busy and the device's synchroniser
    task automatic link_cmd(input logic [7:0] op, input logic [5:0] nb, input logic [31:0] tx);
        logic [31:0] st;
        axi_wr(4'h4, tx);
        axi_wr(4'h0, {7'h00, wp_lvl, 7'h00, 1'b1, 2'b00, nb, op});
        st = 32'h0000_0001;
        while (st[0] !== 1'b0) begin
            axi_rd(4'hC, st);
        end
        repeat (8) @(posedge clk);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        logic [31:0] d;
        logic [7:0] lop;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(4'h0, d);
        chk_word("ctrl reset", 32'h0100_0000, d);
        chk_sr(8'h00, 8'h00, 1'b0);
        $display("test reset finished");
        link_cmd(OP_SET, 6'h00, 32'h0000_0000);
        chk_sr(8'h02, 8'h00, 1'b0);
        @(posedge clk);
        auto_inc_set <= 1'b1;
        @(posedge clk);
        auto_inc_set <= 1'b0;
        link_cmd(OP_CLR, 6'h00, 32'h0000_0000);
        chk_sr(8'h00, 8'h00, 1'b0);
        $display("test latch finished");
        link_cmd(OP_SET, 6'h00, 32'h0000_0000);
        link_cmd(OP_SRW, 6'h01, 32'h9C00_0000);
        chk_sr(8'h9C, 8'h00, 1'b0);
        wp_lvl = 1'b0;
        link_cmd(OP_ARM, 6'h00, 32'h0000_0000);
        chk_sr(8'h9C, 8'h00, 1'b1);
        link_cmd(OP_SRW, 6'h01, 32'h0000_0000);
        chk_sr(8'h9C, 8'h00, 1'b0);
        wp_lvl = 1'b1;
        link_cmd(OP_ARM, 6'h00, 32'h0000_0000);
        link_cmd(OP_SRW, 6'h02, 32'h0018_0000);
        chk_sr(8'h00, 8'h18, 1'b0);
        wp_lvl = 1'b0;
        link_cmd(OP_ARM, 6'h00, 32'h0000_0000);
        link_cmd(OP_SRW, 6'h01, 32'h8400_0000);
        chk_sr(8'h84, 8'h18, 1'b0);
        link_cmd(OP_ARM, 6'h00, 32'h0000_0000);
        link_cmd(OP_SRW, 6'h01, 32'h0400_0000);
        chk_sr(8'h84, 8'h18, 1'b0);
        wp_lvl = 1'b1;
        link_cmd(OP_ARM, 6'h00, 32'h0000_0000);
        link_cmd(OP_SRW, 6'h03, 32'h0000_0000);
        chk_sr(8'h84, 8'h18, 1'b0);
        link_cmd(OP_ARM, 6'h00, 32'h0000_0000);
        link_cmd(OP_CLR, 6'h00, 32'h0000_0000);
        chk_sr(8'h84, 8'h18, 1'b0);
        link_cmd(OP_SRW, 6'h01, 32'h0000_0000);
        chk_sr(8'h84, 8'h18, 1'b0);
        $display("test protect finished");
        link_cmd(OP_JID, 6'h03, 32'h0000_0000);
        axi_rd(4'h8, d);
        chk_word("jedec id", {8'h00, MFR, TYP, CAP}, d & 32'h00FF_FFFF);
        link_cmd(OP_JID, 6'h01, 32'h0000_0000);
        axi_rd(4'h8, d);
        chk_word("jedec cut", {24'h0000_00, MFR}, d & 32'h0000_00FF);
        for (int i = 0; i < 4; i++) begin
            lop = (i < 2) ? 8'h90 : 8'hAB;
            link_cmd(lop, 6'h07, {16'h0000, 7'h00, i[0], 8'h00});
            axi_rd(4'h8, d);
            chk_word("legacy id", i[0] ? {CAP, MFR, CAP, MFR} : {MFR, CAP, MFR, CAP}, d);
        end
        $display("test ident finished");
        finish_test();
    end
endmodule
`default_nettype wire
